// File: lstcd_cfg.svh
// lstcd_cfg.svh: offsets, field positions, reset values and counts for
// the low-speed timewheel and clock divider block.
// assumes inclusion by bare name from the package only; the top module does not include it.
`ifndef LSTCD_CFG_SVH
`define LSTCD_CFG_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define LSTCD_OFS_CTRL      8'h00
`define LSTCD_OFS_STATUS    8'h04
`define LSTCD_OFS_CTW       8'h08
`define LSTCD_OFS_FTW       8'h0c
`define LSTCD_OFS_BUSDIV    8'h10
`define LSTCD_OFS_DIG_BASE  8'h20
`define LSTCD_OFS_ANA_BASE  8'h40

// ****************************************************************
// control register fields
// ****************************************************************
`define LSTCD_CTRL_CTW_CLR    0
`define LSTCD_CTRL_WAKE_EN    1
`define LSTCD_CTRL_WAKE_IRQ   2
`define LSTCD_CTRL_FTW_EN     3
`define LSTCD_CTRL_FTW_IRQ    4
`define LSTCD_CTRL_WATCH_PWR  5
`define LSTCD_CTRL_SYS_LSB    8
`define LSTCD_CTRL_USB_LSB    12

// status flags, write one to clear
`define LSTCD_ST_WAKE   0
`define LSTCD_ST_FTW    1
`define LSTCD_ST_SEC    2

// divider register fields
`define LSTCD_DIV_SRC_LSB   16
`define LSTCD_DIV_SKEW_LSB  20
`define LSTCD_DIV_EN        31

// ****************************************************************
// reset values and counts
// ****************************************************************
`define LSTCD_RST_DIV       16'h0002
`define LSTCD_RST_FTW_TC    5'h1f
`define LSTCD_RST_CTW_SEL   4'hc
`define LSTCD_MIN_DIV       16'h0002
`define LSTCD_HUNDRED_KHZ_HZ 100000
`define LSTCD_ONE_KHZ_HZ     1000
`define LSTCD_SLOW_DIV       3
`define LSTCD_WATCH_HZ       32768

`endif

// File: lstcd_pkg.sv
// lstcd_pkg.sv: types shared by the timewheel and clock divider block.
// assumes lstcd_cfg.svh is on the include path.
package lstcd_pkg;
   `include "lstcd_cfg.svh"

   // clock source selector values, in mux order
   typedef enum logic [2:0] {
      lstcd_src_main_osc,
      lstcd_src_fast_xtal,
      lstcd_src_route,
      lstcd_src_pll,
      lstcd_src_doubler,
      lstcd_src_hundred_khz,
      lstcd_src_watch_xtal,
      lstcd_src_local
   } lstcd_src_e;

   typedef logic [15:0] lstcd_div_t;
endpackage

// File: lstcd_top.sv
// lstcd_top.sv: low-speed timewheels, watch tick, system and bus clock
// selection and the thirteen programmable clock dividers.
// assumes all clock sources arrive as levels sampled on clk (100 MHz),
// a classic wishbone master and a firmware-side interrupt controller.
//
// Notes on behaviour
// - low-speed outputs at 1, 33, 100 kHz
// - central wheel: 13-bit counter on 1 kHz
// - central wheel halts in hibernate or debug
// - firmware can clear central wheel count
// - periodic wakeup, interrupt separately enabled
// - fast wheel: 5-bit, 100 kHz, auto-restart
// - fast wheel interrupt at each terminal count
// - 33 kHz is 100 kHz divided by three
// - 100 kHz selectable as system clock
// - watch crystal gives one-second tick
// - watch oscillator has two power modes
// - eight routed clocks feed digital dividers
// - all seven sources selectable in distribution
// - system clock selected from sources
// - bus clock divider; cpu clock equals it
// - eight 16-bit digital dividers, any source
// - four analog dividers with skew control
// - divider: mux, divider, resync, deglitch
// - ratio two or more, near 50% duty
// - digital outputs 1..4 chainable to 32 bits via analog dividers
// - usb 48 MHz from doubled 24 MHz
// - usb domain crossings are synchronised
//
// The Wishbone slave port and the address map are this design's own decisions.
`timescale 1ns/100ps

module lstcd_top
   import lstcd_pkg::*;
#(
   parameter int NDIG    = 8,
   parameter int NANA    = 4,
   parameter int WATCH_HZ = `LSTCD_WATCH_HZ
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // raw clock sources
   input  wire logic        main_internal_osc,
   input  wire logic        fast_crystal_osc,
   input  wire logic        route_clock,
   input  wire logic        pll_clock,
   input  wire logic        usb_clock_48,
   input  wire logic        low_speed_osc,
   input  wire logic        watch_crystal_osc,
   input  wire logic [7:0]  divider_route_clock,
   // power state
   input  wire logic        hibernate,
   input  wire logic        debug_halt,
   // low-speed outputs
   output logic             one_khz_clock,
   output logic             thirty_three_khz_clock,
   output logic             hundred_khz_clock,
   output logic [12:0]      central_tick_counter,
   output logic             watch_low_power,
   // wake and interrupt requests
   output logic             wake_req,
   output logic             ctw_irq,
   output logic             ftw_irq,
   output logic             rtc_irq,
   // generated clocks
   output logic             sys_clock,
   output logic             bus_clock,
   output logic             cpu_clock,
   output logic [7:0]       dig_clock,
   output logic [3:0]       ana_clock,
   output logic [1:0]       usb_ref_sel
);

   localparam int NSRC = 7 + 8;
   localparam int NDIV = 1 + NDIG + NANA;
   localparam int ONE_KHZ_DIV =
      `LSTCD_HUNDRED_KHZ_HZ / `LSTCD_ONE_KHZ_HZ;

   // ****************************************************************
   // helpers
   // ****************************************************************
   // byte-lane merge for wishbone writes
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return r;
   endfunction

   // divide ratio below two is raised to two
   function automatic lstcd_div_t clamp(input lstcd_div_t v);
      return (v < `LSTCD_MIN_DIV) ? `LSTCD_MIN_DIV : v;
   endfunction

   // ****************************************************************
   // source synchronisers and edge detection
   // ****************************************************************
   logic [NSRC-1:0] src_raw;
   logic [NSRC-1:0] sync1_reg;
   logic [NSRC-1:0] sync2_reg;
   logic [NSRC-1:0] sync3_reg;
   logic [NSRC-1:0] src_edge;

   assign src_raw = {divider_route_clock, watch_crystal_osc, low_speed_osc,
                     usb_clock_48, pll_clock, route_clock,
                     fast_crystal_osc, main_internal_osc};

   // three flops per source; edges are taken from the second and third
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         sync3_reg <= '0;
      end else begin
         sync1_reg <= src_raw;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
      end
   end

   // edges are global, so a mux switch never fakes an edge
   assign src_edge = sync2_reg & ~sync3_reg;

   // ****************************************************************
   // register file
   // ****************************************************************
   logic [31:0] ctrl_reg;
   logic [2:0]  stat_reg;
   logic [3:0]  ctw_sel_reg;
   logic [4:0]  ftw_tc_reg;
   lstcd_div_t  div_sh_reg [NDIV];
   logic [2:0]  src_sh_reg [NDIV];
   logic [3:0]  skew_reg   [NANA];
   logic [NDIV-1:0] en_reg;
   logic        wr_stb;
   logic [5:0]  widx;
   logic [31:0] rd_mux;
   logic [2:0]  stat_set;
   logic [4:0]  ftw_cnt_reg;

   assign wr_stb = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
   assign widx   = wb_adr_i[7:2];

   // ack one cycle after the request, dropped the cycle after
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      end
   end

   // control and configuration writes
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_reg    <= '0;
         ctw_sel_reg <= `LSTCD_RST_CTW_SEL;
         ftw_tc_reg  <= `LSTCD_RST_FTW_TC;
      end else begin
         ctrl_reg[`LSTCD_CTRL_CTW_CLR] <= 1'b0; // self-clearing pulse
         if (wr_stb && wb_adr_i == `LSTCD_OFS_CTRL) begin
            ctrl_reg <= merge(ctrl_reg, wb_dat_i, wb_sel_i);
         end
         if (wr_stb && wb_adr_i == `LSTCD_OFS_CTW) begin
            ctw_sel_reg <= wb_sel_i[0] ? wb_dat_i[3:0] : ctw_sel_reg;
         end
         if (wr_stb && wb_adr_i == `LSTCD_OFS_FTW) begin
            ftw_tc_reg <= wb_sel_i[0] ? wb_dat_i[4:0] : ftw_tc_reg;
         end
      end
   end

   // divider shadow registers; index 0 is the bus divider
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         for (int n = 0; n < NDIV; n++) begin
            div_sh_reg[n] <= `LSTCD_RST_DIV;
            src_sh_reg[n] <= '0;
         end
         for (int a = 0; a < NANA; a++) begin
            skew_reg[a] <= '0;
         end
         en_reg <= '0;
      end else begin
         for (int n = 0; n < NDIV; n++) begin
            if (wr_stb && (n == 0 ? wb_adr_i == `LSTCD_OFS_BUSDIV :
                n <= NDIG ? widx == 6'(`LSTCD_OFS_DIG_BASE/4 + n - 1) :
                widx == 6'(`LSTCD_OFS_ANA_BASE/4 + n - 1 - NDIG))) begin
               if (wb_sel_i[0]) div_sh_reg[n][7:0]  <= wb_dat_i[7:0];
               if (wb_sel_i[1]) div_sh_reg[n][15:8] <= wb_dat_i[15:8];
               if (wb_sel_i[2]) begin
                  src_sh_reg[n] <= wb_dat_i[`LSTCD_DIV_SRC_LSB +: 3];
               end
               if (wb_sel_i[3]) en_reg[n] <= wb_dat_i[`LSTCD_DIV_EN];
               if (n > NDIG && wb_sel_i[2]) begin
                  skew_reg[n-1-NDIG] <= wb_dat_i[`LSTCD_DIV_SKEW_LSB +: 4];
               end
            end
         end
      end
   end

   // sticky status: a hardware set wins over a same-cycle clear
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         stat_reg <= '0;
      end else if (wr_stb && wb_adr_i == `LSTCD_OFS_STATUS &&
                   wb_sel_i[0]) begin
         stat_reg <= (stat_reg & ~wb_dat_i[2:0]) | stat_set;
      end else begin
         stat_reg <= stat_reg | stat_set;
      end
   end

   // read mux
   always_comb begin
      rd_mux = '0;
      case (wb_adr_i)
         `LSTCD_OFS_CTRL:   rd_mux = ctrl_reg;
         `LSTCD_OFS_STATUS: rd_mux = {29'h0, stat_reg};
         `LSTCD_OFS_CTW:    rd_mux = {3'h0, central_tick_counter,
                                      12'h0, ctw_sel_reg};
         `LSTCD_OFS_FTW:    rd_mux = {19'h0, ftw_cnt_reg, 3'h0, ftw_tc_reg};
         default: begin
            for (int n = 0; n < NDIV; n++) begin
               if (n == 0 ? wb_adr_i == `LSTCD_OFS_BUSDIV :
                   n <= NDIG ? widx == 6'(`LSTCD_OFS_DIG_BASE/4 + n - 1) :
                   widx == 6'(`LSTCD_OFS_ANA_BASE/4 + n - 1 - NDIG)) begin
                  rd_mux = {en_reg[n], 12'h0, src_sh_reg[n], div_sh_reg[n]};
                  if (n > NDIG) begin
                     rd_mux[`LSTCD_DIV_SKEW_LSB +: 4] = skew_reg[n-1-NDIG];
                  end
               end
            end
         end
      endcase
   end

   // read data latched with the ack; unmapped reads give zero
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wb_dat_o <= '0;
      end else if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
         wb_dat_o <= rd_mux;
      end
   end

   // ****************************************************************
   // low-speed clocks
   // ****************************************************************
   logic        hk_edge;
   logic [6:0]  k1_cnt_reg;
   logic [1:0]  k33_cnt_reg;
   logic        one_khz_rise;

   assign hk_edge = src_edge[lstcd_src_hundred_khz];
   assign one_khz_rise = hk_edge && k1_cnt_reg == 7'(ONE_KHZ_DIV - 1);

   // 100 kHz follows the oscillator; 1 kHz and 33 kHz count its edges
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         hundred_khz_clock      <= 1'b0;
         one_khz_clock          <= 1'b0;
         thirty_three_khz_clock <= 1'b0;
         k1_cnt_reg             <= '0;
         k33_cnt_reg            <= '0;
      end else begin
         hundred_khz_clock <= sync2_reg[lstcd_src_hundred_khz];
         if (hk_edge) begin
            k1_cnt_reg <= one_khz_rise ? '0 : k1_cnt_reg + 7'd1;
            one_khz_clock <= k1_cnt_reg < 7'(ONE_KHZ_DIV / 2);
            k33_cnt_reg <= (k33_cnt_reg == 2'(`LSTCD_SLOW_DIV - 1)) ?
                           2'd0 : k33_cnt_reg + 2'd1;
            thirty_three_khz_clock <= k33_cnt_reg == 2'd0;
         end
      end
   end

   // ****************************************************************
   // central and fast timewheels
   // ****************************************************************
   logic [12:0] ctw_next;
   logic [12:0] ctw_mask;
   logic        ctw_step;
   logic        ftw_tc_hit;

   assign ctw_step = one_khz_rise && !hibernate && !debug_halt;
   assign ctw_next = central_tick_counter + 13'd1;
   assign ctw_mask = 13'((14'h1 << ctw_sel_reg) - 14'h1);
   assign ftw_tc_hit = ctrl_reg[`LSTCD_CTRL_FTW_EN] && hk_edge &&
                       ftw_cnt_reg == ftw_tc_reg;

   // central wheel counts 1 kHz edges and wraps freely
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         central_tick_counter <= '0;
      end else if (ctrl_reg[`LSTCD_CTRL_CTW_CLR]) begin
         central_tick_counter <= '0;
      end else if (ctw_step) begin
         central_tick_counter <= ctw_next;
      end
   end

   // fast wheel restarts at its terminal count
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ftw_cnt_reg <= '0;
      end else if (!ctrl_reg[`LSTCD_CTRL_FTW_EN]) begin
         ftw_cnt_reg <= '0;
      end else if (hk_edge) begin
         ftw_cnt_reg <= ftw_tc_hit ? '0 : ftw_cnt_reg + 5'd1;
      end
   end

   // ****************************************************************
   // watch tick and event flags
   // ****************************************************************
   logic [15:0] sec_cnt_reg;
   logic        sec_hit;

   assign sec_hit = src_edge[lstcd_src_watch_xtal] &&
                    sec_cnt_reg == 16'(WATCH_HZ - 1);

   // one-second tick counted straight off the watch crystal
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sec_cnt_reg <= '0;
      end else if (src_edge[lstcd_src_watch_xtal]) begin
         sec_cnt_reg <= sec_hit ? '0 : sec_cnt_reg + 16'd1;
      end
   end

   always_comb begin
      stat_set = '0;
      stat_set[`LSTCD_ST_WAKE] = ctw_step && ctrl_reg[`LSTCD_CTRL_WAKE_EN]
                                 && (ctw_next & ctw_mask) == '0;
      stat_set[`LSTCD_ST_FTW]  = ftw_tc_hit;
      stat_set[`LSTCD_ST_SEC]  = sec_hit;
   end

   // requests are levels held until firmware clears the flag
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wake_req        <= 1'b0;
         ctw_irq         <= 1'b0;
         ftw_irq         <= 1'b0;
         rtc_irq         <= 1'b0;
         watch_low_power <= 1'b0;
         usb_ref_sel     <= '0;
      end else begin
         wake_req <= stat_reg[`LSTCD_ST_WAKE];
         ctw_irq  <= stat_reg[`LSTCD_ST_WAKE] &
                     ctrl_reg[`LSTCD_CTRL_WAKE_IRQ];
         ftw_irq  <= stat_reg[`LSTCD_ST_FTW] &
                     ctrl_reg[`LSTCD_CTRL_FTW_IRQ];
         rtc_irq  <= stat_reg[`LSTCD_ST_SEC];
         watch_low_power <= ctrl_reg[`LSTCD_CTRL_WATCH_PWR];
         usb_ref_sel <= ctrl_reg[`LSTCD_CTRL_USB_LSB +: 2];
      end
   end

   // ****************************************************************
   // system clock selection
   // ****************************************************************
   logic [2:0] sys_act_reg;
   logic [2:0] sys_req;

   assign sys_req = ctrl_reg[`LSTCD_CTRL_SYS_LSB +: 3];

   // switch only while the old source is low, avoiding a runt high
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sys_act_reg <= '0;
         sys_clock   <= 1'b0;
      end else begin
         if (!sync2_reg[sys_act_reg] && sys_req != 3'(lstcd_src_local)) begin
            sys_act_reg <= sys_req;
         end
         sys_clock <= sync2_reg[sys_act_reg];
      end
   end

   // ****************************************************************
   // dividers: 0 bus, 1..8 digital, 9..12 analog
   // ****************************************************************
   logic [NDIV-1:0] div_q;
   logic [NDIG-1:0] dig_prev_reg;
   logic [15:0]     skew_sr_reg [NANA];

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         dig_prev_reg <= '0;
      end else begin
         dig_prev_reg <= div_q[NDIG:1];
      end
   end

   for (genvar n = 0; n < NDIV; n++) begin : g_div
      lstcd_div_t cnt_reg;
      lstcd_div_t div_act_reg;
      logic [2:0] src_act_reg;
      logic [7:0] edges;
      logic       ed;
      logic       tc;

      // slot 7: routed clock for digital, digital output for analog
      always_comb begin
         edges = {1'b0, src_edge[6:0]};
         if (n >= 1 && n <= NDIG) begin
            edges[7] = src_edge[7 + n - 1];
         end else if (n > NDIG) begin
            edges[7] = div_q[n-NDIG] & ~dig_prev_reg[n-NDIG-1];
         end
      end

      assign ed = edges[n == 0 ? sys_act_reg : src_act_reg];
      assign tc = cnt_reg >= div_act_reg - 16'd1;

      always_ff @(posedge clk or negedge rstn) begin
         if (!rstn) begin
            cnt_reg     <= '0;
            div_act_reg <= `LSTCD_RST_DIV;
            src_act_reg <= '0;
            div_q[n]    <= 1'b0;
         end else if (n != 0 && !en_reg[n]) begin
            cnt_reg     <= '0;
            div_act_reg <= clamp(div_sh_reg[n]);
            src_act_reg <= src_sh_reg[n];
            div_q[n]    <= 1'b0;
         end else if (ed) begin
            if (tc) begin
               cnt_reg     <= '0;
               div_act_reg <= clamp(div_sh_reg[n]);
               src_act_reg <= src_sh_reg[n];
               div_q[n]    <= 1'b1;
            end else begin
               cnt_reg  <= cnt_reg + 16'd1;
               div_q[n] <= cnt_reg + 16'd1 < (div_act_reg >> 1);
            end
         end
      end
   end

   // analog skew: outputs delayed by the programmed count plus two clk cycles
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         for (int a = 0; a < NANA; a++) begin
            skew_sr_reg[a] <= '0;
         end
         ana_clock <= '0;
      end else begin
         for (int a = 0; a < NANA; a++) begin
            skew_sr_reg[a] <= {skew_sr_reg[a][14:0], div_q[1+NDIG+a]};
            ana_clock[a] <= skew_sr_reg[a][skew_reg[a]];
         end
      end
   end

   // registered clock outputs; cpu clock is the bus clock itself
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         bus_clock <= 1'b0;
         cpu_clock <= 1'b0;
         dig_clock <= '0;
      end else begin
         bus_clock <= div_q[0];
         cpu_clock <= div_q[0];
         dig_clock <= div_q[NDIG:1];
      end
   end

endmodule

// File: lstcd_top_asserts.sv
// lstcd_top_asserts.sv: port checker for lstcd_top.
// assumes one clk domain and the async active-low rstn.
`timescale 1ns/100ps
module lstcd_top_asserts (
   // clock and reset
   input wire logic        clk,
   input wire logic        rstn,
   // bus and power state
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic        wb_ack_o,
   input wire logic        hibernate,
   input wire logic        debug_halt,
   // wheels and events
   input wire logic [12:0] central_tick_counter,
   input wire logic        wake_req,
   input wire logic        ctw_irq,
   input wire logic        ftw_irq,
   input wire logic        rtc_irq,
   // clocks
   input wire logic        bus_clock,
   input wire logic        cpu_clock,
   input wire logic [7:0]  dig_clock
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   logic wr;
   // any write may clear a flag, so the hold checks skip it
   assign wr = wb_cyc_i && wb_stb_i && wb_we_i;
   AST_CPU_BUS: assert property (cpu_clock == bus_clock)
      else $error("cpu clock differs from bus clock");
   AST_HALT: assert property ((hibernate || debug_halt) [*4] ##0 !wb_cyc_i
      |=> $stable(central_tick_counter)) else $error("wheel ran in halt");
   AST_STEP: assert property ($changed(central_tick_counter) |->
      central_tick_counter == 13'h0 ||
      central_tick_counter == $past(central_tick_counter) + 13'h1)
      else $error("wheel jumped");
   AST_WAKE_IRQ: assert property (ctw_irq |-> wake_req)
      else $error("wake irq without flag");
   AST_WAKE_HOLD: assert property (wake_req && !wr && !$past(wr)
      |=> wake_req) else $error("wake flag lost");
   AST_FTW_HOLD: assert property (ftw_irq && !wr && !$past(wr)
      |=> ftw_irq) else $error("fast irq lost");
   AST_RTC_HOLD: assert property (rtc_irq && !wr && !$past(wr)
      |=> rtc_irq) else $error("second irq lost");
   AST_DIV_MIN: assert property ($rose(dig_clock[0]) |=> dig_clock[0])
      else $error("divider runt pulse");
   AST_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
      |=> wb_ack_o ##1 !wb_ack_o) else $error("bad ack timing");
   // main event scenarios
   cover property ($rose(ftw_irq));
   cover property ($rose(ctw_irq));
   cover property ($rose(rtc_irq));
endmodule

bind lstcd_top lstcd_top_asserts i_lstcd_top_asserts (
   .clk(clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .hibernate(hibernate),
   .debug_halt(debug_halt), .central_tick_counter(central_tick_counter),
   .wake_req(wake_req), .ctw_irq(ctw_irq), .ftw_irq(ftw_irq),
   .rtc_irq(rtc_irq), .bus_clock(bus_clock), .cpu_clock(cpu_clock),
   .dig_clock(dig_clock));

// File: lstcd_top_tb.sv
// lstcd_top_tb.sv: self-checking bench for lstcd_top.
// assumes the package is compiled first; WATCH_HZ shortens the second.
`timescale 1ns/100ps
module lstcd_top_tb;
   typedef struct {logic [7:0] a; logic [31:0] d, m, e;} lstcd_row_s;
   logic clk = 0, rstn = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
   logic [7:0] wb_adr_i = 0, divider_route_clock = 0, dig_clock;
   logic [3:0] wb_sel_i = 0, cnt = 0, ana_clock;
   logic [31:0] wb_dat_i = 0, wb_dat_o, q;
   logic wb_ack_o, hibernate = 0, debug_halt = 0, main_internal_osc = 0;
   logic fast_crystal_osc = 0, route_clock = 0, pll_clock = 0;
   logic usb_clock_48 = 0, low_speed_osc = 0, watch_crystal_osc = 0;
   logic one_khz_clock, thirty_three_khz_clock, hundred_khz_clock;
   logic watch_low_power, wake_req, ctw_irq, ftw_irq, rtc_irq;
   logic sys_clock, bus_clock, cpu_clock;
   logic [12:0] central_tick_counter, c;
   logic [1:0] usb_ref_sel;
   int fail_count = 0, check_count = 0, h, t, d, y, u, w;
   // address, write data, read mask, expected read
   lstcd_row_s rows [8] = '{
      '{8'h0c, 32'h3, 32'h1f, 32'h3},
      '{8'h08, 32'h0, 32'hf, 32'h0},
      '{8'h20, 32'h0005_0004, 32'h8007_ffff, 32'h0005_0004},
      '{8'h3c, 32'h0007_0010, 32'h8007_ffff, 32'h0007_0010},
      '{8'h40, 32'h0030_0003, 32'h80f7_ffff, 32'h0030_0003},
      '{8'h10, 32'h2, 32'hffff, 32'h2},
      '{8'h80, 32'hffff_ffff, 32'hffff_ffff, 32'h0},
      '{8'h00, 32'h2520, 32'h3f3e, 32'h2520}};

   lstcd_top #(.WATCH_HZ(4)) i_lstcd_top (
      .clk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
      .wb_dat_i, .wb_dat_o, .wb_ack_o, .main_internal_osc,
      .fast_crystal_osc, .route_clock, .pll_clock, .usb_clock_48,
      .low_speed_osc, .watch_crystal_osc, .divider_route_clock,
      .hibernate, .debug_halt, .one_khz_clock, .thirty_three_khz_clock,
      .hundred_khz_clock, .central_tick_counter, .watch_low_power,
      .wake_req, .ctw_irq, .ftw_irq, .rtc_irq, .sys_clock, .bus_clock,
      .cpu_clock, .dig_clock, .ana_clock, .usb_ref_sel);

   initial forever #5 clk = ~clk;
   // all sources from one counter so their rates are known exactly
   always @(posedge clk) begin
      cnt <= cnt + 4'h1;
      main_internal_osc <= cnt[1];
      low_speed_osc <= cnt[1];
      fast_crystal_osc <= cnt[0];
      pll_clock <= cnt[0];
      usb_clock_48 <= cnt[0];
      route_clock <= cnt[2];
      watch_crystal_osc <= cnt[2];
      divider_route_clock <= {8{cnt[3]}};
   end
   always @(posedge hundred_khz_clock) h++;
   always @(posedge thirty_three_khz_clock) t++;
   always @(posedge dig_clock[0]) d++;
   always @(posedge sys_clock) y++;
   always @(posedge bus_clock) u++;
   always @(posedge one_khz_clock) w++;

   task automatic results;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
         fail_count++;
      end
   endtask
   // classic cycle: hold until ack, release at the ack edge
   task automatic wb(input logic we, input logic [7:0] a,
                     input logic [31:0] dat, output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge clk);
      wb_cyc_i <= 1;
      wb_stb_i <= 1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= dat;
      wb_sel_i <= 4'hf;
      do begin
         @(posedge clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      rd = wb_dat_o;
      wb_cyc_i <= 0;
      wb_stb_i <= 0;
      if (n >= 50) begin
         fail_count++;
         results;
      end
   endtask
   task automatic wait_sig(input int k, input int lim);
      int n;
      logic s;
      n = 0;
      s = 0;
      while (s !== 1'b1 && n < lim) begin
         @(negedge clk);
         s = (k == 0) ? ftw_irq : (k == 1) ? ctw_irq : rtc_irq;
         n++;
      end
      check({31'h0, s}, 1);
      if (s !== 1'b1)
         results;
   endtask

   initial begin
      repeat (8) @(posedge clk);
      rstn <= 1;
      foreach (rows[i]) begin
         wb(1, rows[i].a, rows[i].d, q);
         wb(0, rows[i].a, 0, q);
         check(q & rows[i].m, rows[i].e);
      end
      check({31'h0, watch_low_power}, 1);
      check({30'h0, usb_ref_sel}, 2);
      $display("table test done");
      // divider /4 on the same rate as the slow source
      wb(1, 8'h20, 32'h8000_0004, q);
      repeat (64) @(posedge clk);
      h = 0;
      t = 0;
      d = 0;
      y = 0;
      u = 0;
      w = 0;
      repeat (640) @(posedge clk);
      check({31'h0, d * 4 >= h - 4 && d * 4 <= h + 4}, 1);
      check({31'h0, t * 3 >= h - 3 && t * 3 <= h + 3}, 1);
      check({31'h0, h >= 150}, 1);
      check({31'h0, y >= h - 2 && y <= h + 2}, 1);
      check({31'h0, u * 2 >= h - 4 && u * 2 <= h + 4}, 1);
      check({31'h0, w * 100 >= h - 99 && w * 100 <= h + 99}, 1);
      wb(1, 8'h00, 32'h18, q);
      wait_sig(0, 400);
      wb(1, 8'h00, 32'h10, q);
      wb(1, 8'h04, 32'h2, q);
      repeat (2) @(negedge clk);
      check({31'h0, ftw_irq}, 0);
      // hibernate, then debug halt, then free running
      for (int i = 0; i < 3; i++) begin
         @(posedge clk);
         hibernate <= (i == 0);
         debug_halt <= (i == 1);
         repeat (4) @(negedge clk);
         c = central_tick_counter;
         repeat (900) @(negedge clk);
         check({31'h0, (central_tick_counter == c) == (i < 2)}, 1);
      end
      wb(1, 8'h00, 32'h6, q);
      wait_sig(1, 1000);
      wb(1, 8'h00, 32'h1, q);
      @(negedge clk);
      check({31'h0, central_tick_counter <= 13'h1}, 1);
      check({31'h0, wake_req}, 1);
      wb(1, 8'h04, 32'h5, q);
      repeat (2) @(negedge clk);
      check({31'h0, wake_req}, 0);
      wait_sig(2, 200);
      $display("event tests done");
      @(posedge clk);
      rstn <= 0;
      repeat (2) @(posedge clk);
      rstn <= 1;
      wb(0, 8'h08, 0, q);
      check(q & 32'hf, 32'hc);
      wb(0, 8'h0c, 0, q);
      check(q & 32'h1f, 32'h1f);
      wb(0, 8'h20, 0, q);
      check(q, 32'h2);
      $display("reset test done");
      results;
   end
endmodule
